/* pin_sync.v */
// three-stage synchroniser for one pin input with agreement filter
`timescale 1ns/1ps
module pin_sync (
   input  wire clk_sys,
   input  wire srst,
   input  wire pin,
   input  wire init_level,
   output reg  level
);
   reg s1;
   reg s2;
   reg s3;
   // ==========================================
   // s1 only feeds s2; level moves when the two later stages agree
   // stages start at the pin's idle level, so reset shows no false edge or select
   always @(posedge clk_sys) begin
      if (srst) begin
         s1    <= init_level;
         s2    <= init_level;
         s3    <= init_level;
         level <= init_level;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            level <= s3;
      end
   end
endmodule // pin_sync

/* spi_frame_data_phase_port.v */
// serial host port: offset, control and data phase of framed accesses
// How it works
// - every data byte moves most significant bit first
// - variable N-byte length or fixed 1, 2 or 4 byte length
// - variable mode: chip select high ends data phase, any length from one byte
// - read/write bit one means MOSI data bytes are stored
// - variable mode: write bytes keep coming while select low, one burst
// - each burst write byte goes to next higher offset
// - read/write bit zero: device drives data phase on MISO
// - MISO bit valid for host at rising serial clock edge
// - variable mode: read bytes keep coming while select low and clock runs
// - burst read bytes come from consecutive increasing offsets
// - fixed mode length: 01 one, 10 two, 11 four bytes
// - fixed frames use same bit layout as variable frames
// - one-byte fixed write: write bit, code 01, one data byte
// - four-byte fixed write: write bit, code 11, four data bytes
// - read/write bit zero reads, one writes
// - length bits 00 variable, 01/10/11 fixed 1/2/4 bytes
`timescale 1ns/1ps
`include "spi_port_defs.vh"
module spi_frame_data_phase_port (
   input  wire        clk_sys,
   input  wire        srst,
   input  wire        serial_select_n,
   input  wire        sclk,
   input  wire        mosi,
   output reg         miso,
   output wire        miso_oe_n,
   output reg  [15:0] mem_offset,
   output reg  [4:0]  block_select_bits,
   output reg         write_strobe,
   output reg  [7:0]  write_data,
   output reg         read_strobe,
   input  wire [7:0]  read_data,
   output reg         variable_length_mode,
   output reg         fixed_length_mode
);
   // ==========================================
   // pin synchronisers
   wire sel_n_s;
   wire sclk_s;
   wire mosi_s;
   // select starts released so no frame is seen while the stages fill
   pin_sync u_sel (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .pin        (serial_select_n),
      .init_level (1'h1),
      .level      (sel_n_s)
   );

   pin_sync u_clk (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .pin        (sclk),
      .init_level (1'h0),
      .level      (sclk_s)
   );

   pin_sync u_dat (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .pin        (mosi),
      .init_level (1'h0),
      .level      (mosi_s)
   );

   // ==========================================
   // length decode, used for fixed-length frame end
   function [2:0] fixed_bytes;
      input [1:0] mode;
      begin
         case (mode)
            `MODE_FIX1: fixed_bytes = 3'h1;
            `MODE_FIX2: fixed_bytes = 3'h2;
            `MODE_FIX4: fixed_bytes = 3'h4;
            default:    fixed_bytes = 3'h0;
         endcase
      end
   endfunction

   // nonzero length bits: the frame length is counted, not bounded by select
   function is_fixed;
      input [1:0] code;
      begin
         is_fixed = (code != `MODE_VARIABLE);
      end
   endfunction

   localparam ST_HEADER = 2'h0;
   localparam ST_DATA   = 2'h1;

   reg        sclk_d;
   reg [1:0]  state;
   reg [5:0]  hdr_cnt;
   reg [23:0] hdr_shift;
   reg [2:0]  bit_cnt;
   reg [7:0]  rx_shift;
   reg [7:0]  tx_shift;
   reg [2:0]  byte_cnt;
   reg        rw;
   reg [1:0]  mode;
   reg        load_pending;

   // ==========================================
   // edge detection and frame end decode
   wire sclk_rise = sclk_s & ~sclk_d;
   wire sclk_fall = ~sclk_s & sclk_d;
   // select held low by a fixed-mode host never rises, so framing falls to counting
   wire active    = ~sel_n_s;
   wire [23:0] hdr_next = {hdr_shift[22:0], mosi_s};
   wire        fixed_end = is_fixed(mode) && (byte_cnt == fixed_bytes(mode) - 3'h1);

   assign miso_oe_n = ~(active && state == ST_DATA && rw == `RW_READ);

   // ==========================================
   // frame engine
   always @(posedge clk_sys) begin
      if (srst) begin
         sclk_d <= 1'h0;
         state <= ST_HEADER;
         hdr_cnt <= 6'h0;
         hdr_shift <= 24'h0;
         bit_cnt <= 3'h0;
         rx_shift <= 8'h0;
         tx_shift <= 8'h0;
         byte_cnt <= 3'h0;
         rw <= 1'h0;
         mode <= 2'h0;
         load_pending <= 1'h0;
         miso <= 1'h0;
         mem_offset <= 16'h0;
         block_select_bits <= 5'h0;
         write_strobe <= 1'h0;
         write_data <= 8'h0;
         read_strobe <= 1'h0;
         variable_length_mode <= 1'h0;
         fixed_length_mode <= 1'h0;
      end else begin
         sclk_d <= sclk_s;
         write_strobe <= 1'h0;
         read_strobe <= 1'h0;
         if (!active) begin
            state <= ST_HEADER;
            hdr_cnt <= 6'h0;
            bit_cnt <= 3'h0;
            byte_cnt <= 3'h0;
            load_pending <= 1'h0;
         end else begin
            // read data arrives one cycle after the strobe
            if (load_pending) begin
               tx_shift <= read_data;
               miso <= read_data[`BYTE_LAST_BIT];
               load_pending <= 1'h0;
            end
            case (state)
               ST_HEADER: begin
                  if (sclk_rise) begin
                     hdr_shift <= hdr_next;
                     if (hdr_cnt == `HEADER_BITS - 6'h1) begin
                        hdr_cnt <= 6'h0;
                        mem_offset <= hdr_next[23:8];
                        block_select_bits <= hdr_next[`BLOCK_HI:`BLOCK_LO];
                        rw <= hdr_next[`RW_POS];
                        mode <= hdr_next[`MODE_HI:`MODE_LO];
                        variable_length_mode <= ~is_fixed(hdr_next[`MODE_HI:`MODE_LO]);
                        fixed_length_mode <= is_fixed(hdr_next[`MODE_HI:`MODE_LO]);
                        bit_cnt <= 3'h0;
                        byte_cnt <= 3'h0;
                        state <= ST_DATA;
                        if (hdr_next[`RW_POS] == `RW_READ) begin
                           read_strobe <= 1'h1;
                           load_pending <= 1'h1;
                        end
                     end else begin
                        hdr_cnt <= hdr_cnt + 6'h1;
                     end
                  end
               end
               ST_DATA: begin
                  // shift out on falling edge so the bit is stable at the host's rising edge
                  if (sclk_fall && rw == `RW_READ && !load_pending && bit_cnt != 3'h0) begin
                     miso <= tx_shift[`BYTE_LAST_BIT - bit_cnt];
                  end
                  if (sclk_rise) begin
                     rx_shift <= {rx_shift[6:0], mosi_s};
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == `BYTE_LAST_BIT) begin
                        if (rw == `RW_WRITE) begin
                           write_strobe <= 1'h1;
                           write_data <= {rx_shift[6:0], mosi_s};
                        end
                        if (fixed_end) begin
                           state <= ST_HEADER;
                           hdr_cnt <= 6'h0;
                        end else begin
                           byte_cnt <= byte_cnt + 3'h1;
                           if (rw == `RW_READ) begin
                              mem_offset <= mem_offset + 16'h1;
                              read_strobe <= 1'h1;
                              load_pending <= 1'h1;
                           end
                        end
                     end
                  end
                  // the write offset steps after the stored byte's strobe has been seen
                  if (write_strobe && rw == `RW_WRITE)
                     mem_offset <= mem_offset + 16'h1;
               end
               default: state <= ST_HEADER;
            endcase
         end
      end
   end
endmodule // spi_frame_data_phase_port

/* spi_frame_data_phase_port_tb.sv */
// self-checking bench for the serial host port
`timescale 1ns/1ps
module spi_frame_data_phase_port_tb;
   reg         clk_sys = 1'h0, srst = 1'h1, fix, rw;
   reg  [7:0]  read_data = 8'h00;
   reg  [1:0]  om;
   reg  [2:0]  n;
   reg  [15:0] off;
   reg  [4:0]  blk;
   reg  [27:0] rows [0:5];
   reg  [28:0] wq [$];
   integer     error_cnt = 0, total_checks = 0, r, k;
   wire        sel_n, sclk, mosi, miso, oe_n, wr, rd, vm, fm;
   // a released data line shows the inverse of its last bit, so a late enable is caught
   wire        miso_pin = oe_n ? ~miso : miso;
   wire [15:0] ofs;
   wire [4:0]  bo;
   wire [7:0]  wd;
   spi_frame_data_phase_port dut (.clk_sys(clk_sys), .srst(srst), .serial_select_n(sel_n), .sclk(sclk), .mosi(mosi),
      .miso(miso), .miso_oe_n(oe_n), .mem_offset(ofs), .block_select_bits(bo), .write_strobe(wr), .write_data(wd),
      .read_strobe(rd), .read_data(read_data), .variable_length_mode(vm), .fixed_length_mode(fm));
   spi_host_model host (.serial_select_n(sel_n), .sclk(sclk), .mosi(mosi), .miso(miso_pin));
   initial forever #20 clk_sys = ~clk_sys;
   // store model: fetched byte ready by the next rising edge
   always @(negedge clk_sys) if (rd) read_data <= ofs[7:0] ^ 8'h5A;
   always @(posedge clk_sys) if (wr) wq.push_back({bo, ofs, wd});
   task check(input [31:0] exp, input [31:0] got, input [8*5:1] what);
      begin
         total_checks = total_checks + 1;
         error_cnt = error_cnt + (exp !== got);
         if (exp !== got) $display("Error %0s expected %h seen %h", what, exp, got);
      end
   endtask
   task conclude;
      begin
         $display("checks %0d errors %0d", total_checks, error_cnt);
         if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      #2000000 error_cnt = error_cnt + 1;
      conclude;
   end
   initial begin
      // rows: fixed, rw, length code, bytes, offset, block
      rows[0] = {1'h0, 1'h1, 2'h0, 3'h5, 16'h0040, 5'h06};
      rows[1] = {1'h0, 1'h0, 2'h0, 3'h5, 16'h0100, 5'h0F};
      rows[2] = {1'h1, 1'h1, 2'h1, 3'h1, 16'h1234, 5'h01};
      rows[3] = {1'h1, 1'h1, 2'h2, 3'h2, 16'h0FFF, 5'h02};
      rows[4] = {1'h1, 1'h1, 2'h3, 3'h4, 16'h00FE, 5'h03};
      rows[5] = {1'h1, 1'h0, 2'h3, 3'h4, 16'h2000, 5'h1F};
      repeat (20) @(negedge clk_sys);
      srst = 1'h0;
      for (r = 0; r < 6; r = r + 1) begin
         {fix, rw, om, n, off, blk} = rows[r];
         wq.delete();
         host.frame(off, {blk, rw, om}, n, fix);
         repeat (10) @(negedge clk_sys);
         check(rw ? n : 3'h0, wq.size(), "count");
         for (k = 0; k < n; k = k + 1) begin
            if (rw) check({blk, off + k[15:0], 8'h11 * (k[7:0] + 8'h1)}, wq[k], "write");
            else check((off[7:0] + k[7:0]) ^ 8'h5A, host.rxb[k], "read");
         end
         check({~fix, fix}, {vm, fm}, "mode");
      end
      // second reset in mid-run, then a frame cut short by select
      host.serial_select_n = 1'h1;
      @(negedge clk_sys) srst = 1'h1;
      repeat (2) @(negedge clk_sys);
      srst = 1'h0;
      check(21'h100000, {oe_n, ofs, wr, rd, vm, fm}, "reset");
      wq.delete();
      host.frame(16'hFFFF, 8'hFF, 3'h0, 1'h0);
      host.frame(16'h0555, 8'h54, 3'h1, 1'h0);
      repeat (10) @(negedge clk_sys);
      check(32'h1, wq.size(), "count");
      check({5'h0A, 16'h0555, 8'h11}, wq[0], "abort");
      conclude;
   end
endmodule // spi_frame_data_phase_port_tb

/* spi_host_model.sv */
// host-side serial master model
`timescale 1ns/1ps
module spi_host_model (
   output reg  serial_select_n,
   output reg  sclk,
   output reg  mosi,
   input  wire miso
);
   reg [7:0] rxb [0:7];
   initial {serial_select_n, sclk, mosi} = 3'h4;
   // miso taken late in the high phase: the port sees sclk through a synchroniser
   task xfer(input [7:0] tx, input integer slot);
      integer i;
      for (i = 7; i >= 0; i = i - 1) begin
         mosi = tx[i];
         #160 sclk = 1'h1;
         #150 rxb[slot][i] = miso;
         #10 sclk = 1'h0;
      end
   endtask
   // n of 0 cuts the frame after the offset; data bytes are 11h, 22h, ...
   task frame(input [15:0] off, input [7:0] ctrl, input [2:0] n, input fix);
      integer k;
      begin
         serial_select_n = 1'h0;
         #200 xfer(off[15:8], 7);
         xfer(off[7:0], 7);
         if (n != 3'h0) xfer(ctrl, 7);
         for (k = 0; k < n; k = k + 1) xfer(8'h11 * (k + 1), k);
         mosi = ~mosi;
         #200 if (!fix) serial_select_n = 1'h1;
         #400;
      end
   endtask
endmodule // spi_host_model

/* spi_port_chk.sv */
// assertion checker for the serial host port
`timescale 1ns/1ps
module spi_port_chk (
   input wire        clk_sys,
   input wire        srst,
   input wire        serial_select_n,
   input wire        miso_oe_n,
   input wire [15:0] mem_offset,
   input wire        write_strobe,
   input wire        read_strobe
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   // a byte is eight serial bits, so strobes lie far apart
   sequence s_wr_quiet; !write_strobe [*8]; endsequence
   property p_wr_gap; write_strobe |=> s_wr_quiet; endproperty
   a_wr_gap: assert property (p_wr_gap) else $error("write strobes too close");
   property p_rd_gap; read_strobe |=> !read_strobe [*8]; endproperty
   a_rd_gap: assert property (p_rd_gap) else $error("read strobes too close");
   // 100 cycles reach the next byte of a burst only, never a later frame
   property p_wr_inc; logic [15:0] v;
      (write_strobe, v = mem_offset) ##[1:100] write_strobe |-> mem_offset == v + 16'h1; endproperty
   a_wr_inc: assert property (p_wr_inc) else $error("write offset not next");
   property p_rd_inc; logic [15:0] v;
      (read_strobe, v = mem_offset) ##[1:100] read_strobe |-> mem_offset == v + 16'h1; endproperty
   a_rd_inc: assert property (p_rd_inc) else $error("read offset not next");
   property p_rd_drive; read_strobe |-> ##[0:2] !miso_oe_n; endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("read not driven");
   property p_wr_quiet; write_strobe |-> miso_oe_n; endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("miso driven in write");
   property p_excl; !(write_strobe && read_strobe); endproperty
   a_excl: assert property (p_excl) else $error("read and write together");
   sequence s_sel_high; serial_select_n [*6]; endsequence
   property p_idle; s_sel_high |-> miso_oe_n && !write_strobe && !read_strobe; endproperty
   a_idle: assert property (p_idle) else $error("activity while deselected");
endmodule // spi_port_chk

bind spi_frame_data_phase_port spi_port_chk u_chk (.clk_sys(clk_sys), .srst(srst), .serial_select_n(serial_select_n),
   .miso_oe_n(miso_oe_n), .mem_offset(mem_offset), .write_strobe(write_strobe), .read_strobe(read_strobe));

/* spi_port_defs.vh */
// constants for the serial host port frame logic
`ifndef SPI_PORT_DEFS_VH
`define SPI_PORT_DEFS_VH
// ==========================================
// frame layout
`define OFFSET_BITS     6'h10
`define CTRL_BITS       6'h08
`define HEADER_BITS     6'h18
`define BYTE_LAST_BIT   3'h7
// ==========================================
// control byte fields
`define RW_POS          2
`define MODE_HI         1
`define MODE_LO         0
`define BLOCK_HI        7
`define BLOCK_LO        3
// ==========================================
// length mode and read/write codes
`define MODE_VARIABLE   2'h0
`define MODE_FIX1       2'h1
`define MODE_FIX2       2'h2
`define MODE_FIX4       2'h3
`define RW_READ         1'h0
`define RW_WRITE        1'h1
`endif
